// >>> hw/lcan_top.sv
// Strap configuration, negotiation and parallel detection with AXI4-Lite
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module lcan_top #(
    parameter int PULSE_CYC = lcan_pkg::PULSE_CYC,
    parameter int GAP_CYC   = lcan_pkg::GAP_CYC,
    parameter int ADDR_W    = 12
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // Straps and mode
    input  wire logic [2:0]        indicator_strap_pin,
    input  wire logic              hw_mode,
    // Line side
    output logic                   flp_pulse,
    input  wire logic              rx_word_valid,
    input  wire logic [15:0]       rx_word,
    input  wire logic              nlp_seen,
    input  wire logic              idle_seen,
    // Link status
    output logic                   link_up,
    output logic                   link_100,
    output logic                   link_fdx,
    output logic                   an_done
);
    lcan_pkg::lcan_state_type state_q;

    logic [2:0]  straps_q;
    logic        captured_q;
    logic [2:0]  src;
    logic        load;
    logic        sw_rst_q;
    logic        restart_q;
    logic        an_en_q;
    logic        spd_q;
    logic        fdx_q;
    logic [15:0] adv_q;
    logic [15:0] nptx_q;
    logic [15:0] lpa_q;
    logic [15:0] nprx_q;
    logic [15:0] last_q;
    logic [1:0]  same_q;
    logic        ack_q;
    logic        page_q;
    logic        res_spd_q;
    logic        res_fdx_q;
    logic [23:0] gap_q;
    logic        aw_full_q;
    logic        w_full_q;
    logic [7:0]  widx_q;
    logic        wbad_q;
    logic [15:0] wv;
    logic        wr_fire;
    logic        wr_ok;
    logic [7:0]  ridx;
    logic [15:0] rd_val;
    logic        rd_bad;
    logic        rd_fire;
    logic        page_ok;
    logic        np_last;
    logic        page_set;
    logic [3:0]  common;
    logic        negot;
    logic [3:0]  adv_nib;

    lcan_flp_if flp ();

    lcan_flp_tx #(
        .PULSE_CYC (PULSE_CYC),
        .POS       (lcan_pkg::FLP_POS)
    ) u_flp (
        .aclk    (aclk),
        .aresetn (aresetn),
        .flp     (flp.tx),
        .pulse   (flp_pulse)
    );

    // Strap capture on the first clock after reset release
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            captured_q <= 1'h0;
            straps_q   <= 3'h0;
        end
        else if (!captured_q)
        begin
            captured_q <= 1'h1;
            straps_q   <= indicator_strap_pin;
        end
    end

    assign load    = !captured_q || sw_rst_q;
    assign src     = captured_q ? straps_q : indicator_strap_pin;
    assign adv_nib = src[0] ?
        lcan_pkg::ADV_TABLE[{src[1], src[2], 2'h0} +: 4] :
        lcan_pkg::ADV_ALL;
    assign wr_ok   = wr_fire && !hw_mode && !wbad_q;

    // Control and advertisement registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            an_en_q <= 1'h0;
            spd_q   <= 1'h0;
            fdx_q   <= 1'h0;
            adv_q   <= 16'h0000;
        end
        else if (load)
        begin
            an_en_q <= src[0];
            spd_q   <= src[0] | src[1];
            fdx_q   <= src[2];
            adv_q   <= {7'h00, adv_nib, lcan_pkg::ADV_SEL};
        end
        else if (wr_ok && widx_q == lcan_pkg::IDX_CTRL)
        begin
            an_en_q <= wv[lcan_pkg::CTRL_AN];
            spd_q   <= wv[lcan_pkg::CTRL_SPD];
            fdx_q   <= wv[lcan_pkg::CTRL_FDX];
        end
        else if (wr_ok && widx_q == lcan_pkg::IDX_ADV)
            adv_q <= wv;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            nptx_q <= 16'h0000;
        else if (wr_ok && widx_q == lcan_pkg::IDX_NPTX)
            nptx_q <= wv;
    end

    // Software reset and negotiation restart pulses
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sw_rst_q  <= 1'h0;
            restart_q <= 1'h0;
        end
        else
        begin
            sw_rst_q  <= wr_ok && widx_q == lcan_pkg::IDX_CTRL &&
                         wv[lcan_pkg::CTRL_RST];
            restart_q <= load || (wr_ok && widx_q == lcan_pkg::IDX_CTRL &&
                         (wv[lcan_pkg::CTRL_RESTART] ||
                          (wv[lcan_pkg::CTRL_AN] && !an_en_q)));
        end
    end

    // Page acceptance terms
    assign common   = adv_q[8:5] & rx_word[8:5];
    assign page_ok  = state_q == lcan_pkg::ST_BASE && rx_word_valid &&
                      rx_word == last_q &&
                      same_q == 2'(lcan_pkg::SAME_PAGES - 1);
    assign np_last  = state_q == lcan_pkg::ST_NEXT && rx_word_valid &&
                      !rx_word[lcan_pkg::WORD_NP] &&
                      !nptx_q[lcan_pkg::WORD_NP];
    assign page_set = page_ok ||
                      (state_q == lcan_pkg::ST_NEXT && rx_word_valid);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_q <= lcan_pkg::ST_FORCED;
        else if (!an_en_q)
            state_q <= lcan_pkg::ST_FORCED;
        else if (restart_q)
            state_q <= lcan_pkg::ST_BASE;
        else
        begin
            case (state_q)
                lcan_pkg::ST_FORCED:
                    state_q <= lcan_pkg::ST_BASE;
                lcan_pkg::ST_BASE:
                    if (nlp_seen)
                        state_q <= adv_q[lcan_pkg::ADV_10H] ?
                            lcan_pkg::ST_PD_UP : lcan_pkg::ST_NOLINK;
                    else if (idle_seen)
                        state_q <= adv_q[lcan_pkg::ADV_100H] ?
                            lcan_pkg::ST_PD_UP : lcan_pkg::ST_NOLINK;
                    else if (page_ok && common == 4'h0)
                        state_q <= lcan_pkg::ST_NOLINK;
                    else if (page_ok)
                        state_q <= adv_q[lcan_pkg::WORD_NP] &&
                                   rx_word[lcan_pkg::WORD_NP] ?
                            lcan_pkg::ST_NEXT : lcan_pkg::ST_AN_UP;
                lcan_pkg::ST_NEXT:
                    if (np_last)
                        state_q <= lcan_pkg::ST_AN_UP;
                default:
                    state_q <= state_q;
            endcase
        end
    end

    // Resolved speed and duplex
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            res_spd_q <= 1'h0;
            res_fdx_q <= 1'h0;
        end
        else if (state_q == lcan_pkg::ST_BASE && (nlp_seen || idle_seen))
        begin
            res_spd_q <= !nlp_seen;
            res_fdx_q <= 1'h0;
        end
        else if (page_ok)
        begin
            res_spd_q <= common[3] || common[2];
            res_fdx_q <= common[3] || (!common[2] && common[1]);
        end
    end

    // Partner page capture and identical page count
    always_ff @(posedge aclk)
    begin
        if (!aresetn || restart_q)
        begin
            same_q <= 2'h0;
            last_q <= 16'h0000;
            ack_q  <= 1'h0;
        end
        else if (state_q == lcan_pkg::ST_BASE && rx_word_valid)
        begin
            last_q <= rx_word;
            if (rx_word != last_q || same_q == 2'h0)
                same_q <= 2'h1;
            else if (same_q != 2'(lcan_pkg::SAME_PAGES))
                same_q <= same_q + 2'h1;
            if (page_ok)
                ack_q <= 1'h1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            lpa_q  <= 16'h0000;
            nprx_q <= 16'h0000;
        end
        else if (page_ok)
            lpa_q <= rx_word;
        else if (state_q == lcan_pkg::ST_NEXT && rx_word_valid)
            nprx_q <= rx_word;
    end

    // Page received flag: set wins over both clears
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            page_q <= 1'h0;
        else if (page_set)
            page_q <= 1'h1;
        else if (restart_q)
            page_q <= 1'h0;
        else if (rd_fire && ridx == lcan_pkg::IDX_EXP)
            page_q <= 1'h0;
    end

    // Burst scheduling
    assign negot      = state_q == lcan_pkg::ST_BASE ||
                        state_q == lcan_pkg::ST_NEXT;
    assign flp.start  = negot && !flp.busy && gap_q == 24'h00_0000;
    assign flp.word   = state_q == lcan_pkg::ST_NEXT ? nptx_q :
                        {adv_q[15], ack_q, adv_q[13:0]};

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !negot)
            gap_q <= 24'h00_0000;
        else if (flp.start)
            gap_q <= 24'(GAP_CYC);
        else if (gap_q != 24'h00_0000)
            gap_q <= gap_q - 24'h00_0001;
    end

    assign link_up  = state_q == lcan_pkg::ST_FORCED ||
                      state_q == lcan_pkg::ST_AN_UP ||
                      state_q == lcan_pkg::ST_PD_UP;
    assign link_100 = state_q == lcan_pkg::ST_FORCED ? spd_q : res_spd_q;
    assign link_fdx = state_q == lcan_pkg::ST_FORCED ? fdx_q : res_fdx_q;
    assign an_done  = state_q == lcan_pkg::ST_AN_UP;

    // AXI4-Lite write channel
    assign awready = !aw_full_q && !bvalid;
    assign wready  = !w_full_q && !bvalid;
    assign wr_fire = aw_full_q && w_full_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_q <= 1'h0;
            w_full_q  <= 1'h0;
            widx_q    <= 8'h00;
            wbad_q    <= 1'h0;
            wv        <= 16'h0000;
            bvalid    <= 1'h0;
            bresp     <= lcan_pkg::RESP_OK;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_full_q <= 1'h1;
                widx_q    <= awaddr[9:2];
                wbad_q    <= awaddr[ADDR_W-1:10] != '0;
            end
            if (wvalid && wready)
            begin
                w_full_q <= 1'h1;
                wv       <= {wstrb[1] ? wdata[15:8] : 8'h00,
                             wstrb[0] ? wdata[7:0] : 8'h00};
            end
            if (wr_fire)
            begin
                aw_full_q <= 1'h0;
                w_full_q  <= 1'h0;
                bvalid    <= 1'h1;
                bresp     <= wbad_q || widx_q > lcan_pkg::IDX_NPRX ?
                             lcan_pkg::RESP_ERR : lcan_pkg::RESP_OK;
            end
            else if (bready)
                bvalid <= 1'h0;
        end
    end

    // AXI4-Lite read channel
    assign arready = !rvalid;
    assign rd_fire = arvalid && arready;
    assign ridx    = araddr[9:2];

    always_comb
    begin
        rd_val = 16'h0000;
        rd_bad = araddr[ADDR_W-1:10] != '0;
        if (ridx == lcan_pkg::IDX_CTRL)
            rd_val = {sw_rst_q, 1'h0, spd_q, an_en_q, 3'h0, fdx_q, 8'h00};
        else if (ridx == lcan_pkg::IDX_STAT)
            rd_val = {4'h0, 2'h0, state_q, an_done, link_fdx, link_100,
                      link_up};
        else if (ridx == lcan_pkg::IDX_ADV)
            rd_val = adv_q;
        else if (ridx == lcan_pkg::IDX_LPA)
            rd_val = lpa_q;
        else if (ridx == lcan_pkg::IDX_EXP)
            rd_val = {14'h0000, page_q, 1'h0};
        else if (ridx == lcan_pkg::IDX_NPTX)
            rd_val = nptx_q;
        else if (ridx == lcan_pkg::IDX_NPRX)
            rd_val = nprx_q;
        else
            rd_bad = 1'h1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid <= 1'h0;
            rdata  <= 32'h0000_0000;
            rresp  <= lcan_pkg::RESP_OK;
        end
        else if (rd_fire)
        begin
            rvalid <= 1'h1;
            rdata  <= rd_bad ? 32'h0000_0000 : {16'h0000, rd_val};
            rresp  <= rd_bad ? lcan_pkg::RESP_ERR : lcan_pkg::RESP_OK;
        end
        else if (rready)
            rvalid <= 1'h0;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_strap_forced: assert property (
        $rose(captured_q) && !straps_q[0]
        |-> !an_en_q && spd_q == straps_q[1] && fdx_q == straps_q[2])
        else $error("forced strap values not loaded");
    a_strap_adv: assert property (
        $rose(captured_q) && straps_q[0] |-> an_en_q && spd_q &&
        adv_q[8:5] == lcan_pkg::ADV_TABLE[
            {straps_q[1], straps_q[2], 2'h0} +: 4])
        else $error("strap advertisement wrong");
    a_burst_start: assert property (
        flp.start |=> flp.busy)
        else $error("negotiation burst not started");
    a_three_pages: assert property (
        $past(state_q == lcan_pkg::ST_BASE) &&
        (state_q == lcan_pkg::ST_AN_UP || state_q == lcan_pkg::ST_NEXT)
        |-> $past(same_q) == 2'h2 && $past(rx_word_valid))
        else $error("left base page before three matches");
    a_np_gate: assert property (
        state_q == lcan_pkg::ST_NEXT
        |-> adv_q[lcan_pkg::WORD_NP] && lpa_q[lcan_pkg::WORD_NP])
        else $error("next page without both abilities");
    a_page_clear: assert property (
        restart_q && !page_set |=> !page_q)
        else $error("page flag survived restart");
    a_pd_half: assert property (
        state_q == lcan_pkg::ST_BASE && an_en_q && !restart_q &&
        nlp_seen && adv_q[lcan_pkg::ADV_10H]
        |=> link_up && !link_100 && !link_fdx)
        else $error("parallel detect link not 10 half");
    a_pd_refuse: assert property (
        state_q == lcan_pkg::ST_BASE && an_en_q && !restart_q &&
        nlp_seen && !adv_q[lcan_pkg::ADV_10H] |=> !link_up)
        else $error("link without half duplex ability");
    a_hw_lock: assert property (
        hw_mode && captured_q && !sw_rst_q |=> $stable(adv_q))
        else $error("write changed config in hardware mode");
    a_forced_now: assert property (
        !an_en_q && $past(!an_en_q) |-> link_up && link_100 == spd_q)
        else $error("forced mode not running");
    a_sw_reload: assert property (
        sw_rst_q && straps_q[0] |=> adv_q[8:5] ==
        lcan_pkg::ADV_TABLE[{straps_q[1], straps_q[2], 2'h0} +: 4])
        else $error("software reset did not reload straps");
endmodule : lcan_top

// >>> hw/lcan_pkg.sv
// Constants shared by the link configuration and negotiation block
package lcan_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'h00;
    localparam logic [7:0] IDX_STAT = 8'h01;
    localparam logic [7:0] IDX_ADV  = 8'h04;
    localparam logic [7:0] IDX_LPA  = 8'h05;
    localparam logic [7:0] IDX_EXP  = 8'h06;
    localparam logic [7:0] IDX_NPTX = 8'h07;
    localparam logic [7:0] IDX_NPRX = 8'h08;
    // Control bit positions
    localparam int CTRL_RST     = 15;
    localparam int CTRL_SPD     = 13;
    localparam int CTRL_AN      = 12;
    localparam int CTRL_RESTART = 9;
    localparam int CTRL_FDX     = 8;
    // Link code word bit positions
    localparam int WORD_NP      = 15;
    localparam int WORD_ACK     = 14;
    localparam int ADV_LO       = 5;
    localparam int ADV_10H      = 5;
    localparam int ADV_100H     = 7;
    localparam int EXP_PAGE     = 1;
    localparam logic [4:0] ADV_SEL = 5'h01;
    // Advertised nibble {100F,100H,10F,10H} per strap pins 1,2
    localparam logic [15:0] ADV_TABLE = 16'hF5C4;
    localparam logic [3:0]  ADV_ALL   = 4'hF;
    // Burst timing
    localparam int CLK_NS     = 10;
    localparam int PULSE_NS   = 62500;
    localparam int PULSE_CYC  = PULSE_NS / CLK_NS;
    localparam int FLP_POS    = 33;
    localparam int WORD_W     = 16;
    localparam int SAME_PAGES = 3;
    localparam int GAP_CYC    = 1600000;
    // AXI responses
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    typedef enum logic [5:0] {
        ST_FORCED = 6'h01,
        ST_BASE   = 6'h02,
        ST_NEXT   = 6'h04,
        ST_AN_UP  = 6'h08,
        ST_PD_UP  = 6'h10,
        ST_NOLINK = 6'h20
    } lcan_state_type;
endpackage : lcan_pkg

// >>> hw/lcan_flp_if.sv
// Burst request carrier between negotiation control and pulse sender
`timescale 1ns/100ps
interface lcan_flp_if;
    logic        start;
    logic [15:0] word;
    logic        busy;
    modport ctrl (output start, output word, input busy);
    modport tx   (input start, input word, output busy);
endinterface : lcan_flp_if

// >>> hw/lcan_flp_tx.sv
// Fast link pulse burst sender
`timescale 1ns/100ps
module lcan_flp_tx #(
    parameter int PULSE_CYC = lcan_pkg::PULSE_CYC,
    parameter int POS       = lcan_pkg::FLP_POS
) (
    // Clock and reset
    input  wire logic  aclk,
    input  wire logic  aresetn,
    // Burst request
    lcan_flp_if.tx     flp,
    // Line pulse
    output logic       pulse
);
    localparam int TW = $clog2(PULSE_CYC);

    logic [TW-1:0] tick_q;
    logic [5:0]    pos_q;
    logic [15:0]   word_q;
    logic          busy_q;
    logic [5:0]    pcnt_q;

    assign flp.busy = busy_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            busy_q <= 1'h0;
            tick_q <= '0;
            pos_q  <= 6'h00;
            word_q <= 16'h0000;
        end
        else if (!busy_q)
        begin
            busy_q <= flp.start;
            tick_q <= '0;
            pos_q  <= 6'h00;
            if (flp.start)
                word_q <= flp.word;
        end
        else if (tick_q == TW'(PULSE_CYC - 1))
        begin
            tick_q <= '0;
            pos_q  <= pos_q + 6'h01;
            if (pos_q == 6'(POS - 1))
                busy_q <= 1'h0;
        end
        else
            tick_q <= tick_q + TW'(1);
    end

    // Even index is a clock position, odd index carries bit pos/2
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pulse <= 1'h0;
        else
            pulse <= busy_q && tick_q == '0 &&
                     (!pos_q[0] || word_q[pos_q[4:1]]);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !busy_q)
            pcnt_q <= 6'h00;
        else if (pulse)
            pcnt_q <= pcnt_q + 6'h01;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_pulse_spacing: assert property (
        pulse |-> busy_q && tick_q == TW'(1))
        else $error("link pulse off its position grid");
    a_burst_length: assert property (
        $fell(busy_q) |-> pcnt_q <= 6'(POS))
        else $error("burst carried too many pulses");
    a_clock_pulse: assert property (
        busy_q && tick_q == '0 && !pos_q[0] |=> pulse)
        else $error("clock position left empty");
    a_data_pulse: assert property (
        busy_q && tick_q == '0 && pos_q[0]
        |=> pulse == word_q[pos_q[4:1]])
        else $error("data position does not match word bit");
endmodule : lcan_flp_tx

// >>> test/lcan_lp_model.sv
// Link partner model driving decoded pages and detect flags
`timescale 1ns/100ps
module lcan_lp_model (
    // Clock
    input  wire logic   aclk,
    // Line side
    output logic        rx_word_valid,
    output logic [15:0] rx_word,
    output logic        nlp_seen,
    output logic        idle_seen
);
    initial
    begin
        {rx_word_valid, nlp_seen, idle_seen} = 3'h0;
        rx_word = 16'h0000;
    end
    // One word per burst, repeated; word shows the inverse between bursts
    task automatic send(input logic [15:0] w, input int k);
        repeat (k)
        begin
            @(posedge aclk);
            rx_word_valid <= 1'b1;
            rx_word <= w;
            @(posedge aclk);
            rx_word_valid <= 1'b0;
            rx_word <= ~w;
            repeat (3) @(posedge aclk);
        end
    endtask : send
    // Non-negotiating partner: link pulses or idle symbols
    task automatic detect(input logic idle);
        @(posedge aclk);
        nlp_seen <= !idle;
        idle_seen <= idle;
        @(posedge aclk);
        {nlp_seen, idle_seen} <= 2'h0;
        repeat (3) @(posedge aclk);
    endtask : detect
endmodule : lcan_lp_model

// >>> test/lcan_top_tb.sv
// Bench for strap setup, negotiation and parallel detection
`timescale 1ns/100ps
module lcan_top_tb;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        hw_mode, awready, wready, bvalid, arready, rvalid;
    logic        flp_pulse, link_up, link_100, link_fdx, an_done;
    logic        rx_word_valid, nlp_seen, idle_seen;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [15:0] rx_word, v;
    logic [3:0]  wstrb, e;
    logic [2:0]  indicator_strap_pin;
    logic [1:0]  bresp, rresp, r;
    int          failures, total_checks, i, k;
    lcan_top #(.PULSE_CYC(4), .GAP_CYC(200)) u_lcan_top (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .indicator_strap_pin(indicator_strap_pin), .hw_mode(hw_mode),
        .flp_pulse(flp_pulse), .rx_word_valid(rx_word_valid),
        .rx_word(rx_word), .nlp_seen(nlp_seen), .idle_seen(idle_seen),
        .link_up(link_up), .link_100(link_100), .link_fdx(link_fdx),
        .an_done(an_done));
    lcan_lp_model u_lcan_lp_model (
        .aclk(aclk), .rx_word_valid(rx_word_valid), .rx_word(rx_word),
        .nlp_seen(nlp_seen), .idle_seen(idle_seen));
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [15:0] x, y);
        total_checks++;
        if (y !== x)
        begin
            $display("BAD %s exp %h got %h", nm, x, y);
            failures++;
        end
    endtask : chk
    // Waits for a bus answer: 0 awready, 1 wready, 2 bvalid, 3 arready
    task automatic wfor(input int sel);
        int   cnt;
        logic s;
        cnt = 0;
        s   = 1'b0;
        while (s !== 1'b1 && cnt < 60)
        begin
            @(negedge aclk);
            cnt++;
            case (sel)
                0: s = awready;
                1: s = wready;
                2: s = bvalid;
                3: s = arready;
                default: s = rvalid;
            endcase
        end
        if (s !== 1'b1)
        begin
            failures++;
            wrap_up();
        end
    endtask : wfor
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        {awaddr, wdata} <= {a, 16'h0000, d};
        {awvalid, wvalid} <= 2'h3;
        fork
            begin
                wfor(0);
                @(posedge aclk);
                awvalid <= 1'b0;
            end
            begin
                wfor(1);
                @(posedge aclk);
                wvalid <= 1'b0;
            end
        join
        wfor(2);
        r = bresp;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        wfor(3);
        @(posedge aclk);
        arvalid <= 1'b0;
        wfor(4);
        {v, r} = {rdata[15:0], rresp};
        @(posedge aclk);
    endtask : rd
    task automatic rst(input logic [2:0] s);
        aresetn <= 1'b0;
        indicator_strap_pin <= s;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
    endtask : rst
    initial
    begin
        {awvalid, wvalid, arvalid, hw_mode, awaddr, araddr, wdata} = '0;
        {bready, rready, wstrb, failures, total_checks} = '1;
        {failures, total_checks} = '0;
        for (i = 0; i < 8; i++)
        begin
            rst(i[2:0]);
            rd(12'h000);
            chk("ctrl", {2'h0, i[0] | i[1], i[0], 3'h0, i[2], 8'h00}, v & 16'h3100);
            rd(12'h010);
            e = i[0] ? 4'(16'hF5C4 >> {i[1], i[2], 2'h0}) : 4'hF;
            chk("adv", 16'(e), 16'(v[8:5]));
            chk("forced", 16'({!i[0], 1'b0}), 16'({link_up, an_done}));
        end
        $display("strap test done");
        k = 0;
        repeat (200)
        begin
            @(negedge aclk);
            k += 32'(flp_pulse);
        end
        @(posedge aclk);
        chk("pulses", 16'd22, k[15:0]);
        u_lcan_lp_model.send(16'h01E1, 2);
        u_lcan_lp_model.send(16'h0061, 1);
        chk("early", 16'h0000, 16'(an_done));
        u_lcan_lp_model.send(16'h0061, 2);
        chk("resolve", 16'hD, 16'({an_done, link_up, link_100, link_fdx}));
        rd(12'h014);
        chk("partner", 16'h0061, v);
        rd(12'h018);
        chk("page", 16'h0002, v & 16'h0002);
        wr(12'h000, 16'h3300);
        @(posedge aclk);
        chk("restart", 16'h0000, 16'(an_done));
        $display("negotiation test done");
        for (i = 0; i < 3; i++)
        begin
            rst(i == 0 ? 3'h3 : 3'h1);
            u_lcan_lp_model.detect(i == 2);
            chk("detect", 16'(6'b110010 >> (2 * i)) & 16'h0003, 16'({link_up, link_100}));
            chk("half", 16'h0000, 16'(link_fdx));
        end
        $display("parallel detect test done");
        rst(3'h7);
        indicator_strap_pin <= 3'h1;
        wr(12'h010, 16'h0021);
        chk("wresp", 16'h0000, 16'(r));
        rd(12'h010);
        chk("advw", 16'h0021, v);
        wr(12'h000, 16'h8000);
        repeat (3) @(posedge aclk);
        rd(12'h010);
        chk("softrst", 16'h01E1, v & 16'h01FF);
        wr(12'h010, 16'h81E1);
        wr(12'h01C, 16'h2001);
        wr(12'h000, 16'h3300);
        u_lcan_lp_model.send(16'h8061, 3);
        u_lcan_lp_model.send(16'h0123, 1);
        rd(12'h020);
        chk("nextrx", 16'h0123, v);
        chk("npdone", 16'h0001, 16'(an_done));
        hw_mode <= 1'b1;
        wr(12'h010, 16'h0000);
        rd(12'h010);
        chk("hwmode", 16'h01E1, v & 16'h01FF);
        rd(12'h008);
        chk("unmapped", 16'h0002, 16'(r));
        $display("reset and mode test done");
        wrap_up();
    end
endmodule : lcan_top_tb
